// file: design/csr_defines.svh
// Register offsets, field positions and reset values
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// Register indices (byte address is four times the index)
`define CSR_IDX_INPUT_CELL 8'h0A
`define CSR_IDX_OUT_A 8'h20
`define CSR_IDX_OUT_B 8'h21
`define CSR_IDX_MASK_A 8'h22
`define CSR_IDX_MASK_B 8'h23
`define CSR_IDX_POWER_0 8'hB0
`define CSR_IDX_POWER_2 8'hB4
`define CSR_IDX_LOCK_LOW 8'hC0
`define CSR_IDX_LOCK_HIGH 8'hC1
`define CSR_IDX_BOOT_LOCK 8'hC2
`define CSR_IDX_SCAN_PORT 8'hC7
`define CSR_IDX_PAGE 8'hE0
`define CSR_IDX_SPACE_MAP 8'hE2
`define CSR_IDX_SIZE_0 8'hF0
`define CSR_IDX_SIZE_1 8'hF1

// Writable bit masks
`define CSR_SCAN_PORT_WMASK 8'h01
`define CSR_POWER_0_WMASK 8'h3A
`define CSR_POWER_2_WMASK 8'h7D
`define CSR_SPACE_MAP_WMASK 8'h9F

// Field positions
`define CSR_P0_AUTO_PD 1
`define CSR_P0_TURBO_OFF 3
`define CSR_P0_ARRAY_CLK_OFF 4
`define CSR_P0_CELL_CLK_OFF 5
`define CSR_P2_ADDR_OFF 0
`define CSR_P2_CTL0_OFF 2
`define CSR_P2_CTL1_OFF 3
`define CSR_P2_CTL2_OFF 4
`define CSR_P2_LATCH_OFF 5
`define CSR_P2_WRH_OFF 6
`define CSR_MAP_SRAM_FETCH 0
`define CSR_MAP_SEC_FETCH 1
`define CSR_MAP_PRI_FETCH 2
`define CSR_MAP_SEC_READ 3
`define CSR_MAP_PRI_READ 4
`define CSR_MAP_PERIPH 7
`define CSR_BOOT_SECURE 7

// Reset values
`define CSR_RESET_BYTE 8'h00

`endif

// file: design/csr_pkg.sv
// Types shared by the register bank
package csr_pkg;
	typedef logic [7:0] csr_byte_t;
	typedef enum logic [1:0]
	{
		CSR_IDLE = 2'b01,
		CSR_DATA = 2'b10
	} csr_state_e;
endpackage : csr_pkg

// file: design/csr_wr_if.sv
// Write strobe bundle from the bus slave to the register bank
`timescale 1ns/100ps
interface csr_wr_if;
	logic wr_en;
	logic rd_en;
	logic [7:0] index;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slave (output wr_en, output rd_en, output index, output wdata, input rdata);
	modport bank (input wr_en, input rd_en, input index, input wdata, output rdata);
endinterface : csr_wr_if

// file: design/csr_ahb_slave.sv
// AHB-Lite slave front end for the byte register bank
`timescale 1ns/100ps
module csr_ahb_slave
	import csr_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic rst, // Sync reset
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic [31:0] hrdata, // Read data
	csr_wr_if.slave rif // Register access
);
	csr_state_e state_ff;
	logic wr_ff;
	logic [7:0] idx_ff;
	logic valid_ff;
	logic take;

	assign take = hsel && hready && htrans[1];
	assign rif.wr_en = (state_ff == CSR_DATA) && wr_ff && valid_ff;
	assign rif.rd_en = 1'b0;
	assign rif.index = idx_ff;
	assign rif.wdata = hwdata[7:0];

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_ff <= CSR_IDLE;
			wr_ff <= 1'b0;
			idx_ff <= 8'h00;
			valid_ff <= 1'b0;
		end
		else
		begin
			state_ff <= take ? CSR_DATA : CSR_IDLE;
			if (take)
			begin
				wr_ff <= hwrite;
				idx_ff <= haddr[9:2];
				valid_ff <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
			end
		end
	end

	// Read data captured in address phase, stands through data phase
	always_ff @(posedge mclk)
	begin
		if (rst)
			hrdata <= 32'h00000000;
		else if (take && !hwrite)
			hrdata <= ((haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00)) ?
				{24'h000000, rif.rdata} : 32'h00000000;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			hreadyout <= 1'b1;
		else
			hreadyout <= 1'b1;
	end
endmodule : csr_ahb_slave

// file: design/csr_bank.sv
// Control and status register bank for the flash-plus-logic peripheral
// What this block does
// - Input cell register reads current state of eight input cells; read-only.
// - Output cell writes load cell flip-flops; reads return present cell outputs.
// - Mask bit at 1 blocks host writes to the matching output cell.
// - Mask bits reset to 0, allowing host writes.
// - Lock low register bit i reports primary sector i protection.
// - Lock high register reports sectors 8 to 15 at bits 0 to 7.
// - Boot lock bits 3:0 report secondary sector protection; bits 6:4 unused.
// - Boot lock bit 7 reports security flag.
// - Scan-port register bit 0 enables serial test port; others unused.
// - Page register drives page inputs to the logic array; resets to zero.
// - Power control 0 clears at power-up only, not on reset.
// - Power control 0 bit 1 enables automatic power-down.
// - Power control 0 bit 3 at 1 turns array turbo off.
// - Power control 0 bits 4 and 5 disconnect the array and cell clocks.
// - Power control 2 bit 0 blocks low address bits from the array.
// - Power control 2 bits 2-6 disconnect control pins, latch and high-byte strobes.
// - Reset clears map bits 0 and 7, loads bits 1-4 from configuration.
// - Map bits 0-4 act only in separate program/data space mode.
// - Map bits gate fetch strobes to each memory and read strobes to both flash memories.
// - Map bit 7 enables peripheral mode of port F.
// - Size register 0 bits 3:0 encode primary flash size.
// - Size register 0 bits 7:4 encode SRAM size.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`include "csr_defines.svh"
module csr_bank
	import csr_pkg::*;
#(
	parameter logic [3:0] PRIMARY_SIZE_CODE = 4'h6, // Primary flash size code
	parameter logic [3:0] SRAM_SIZE_CODE = 4'h5, // SRAM size code
	parameter logic [7:0] SIZE_1_VALUE = 8'h00, // Secondary memory type and size
	parameter logic [3:0] MAP_CONFIG = 4'h0 // Configured map bits 4:1
)
(
	input wire logic mclk, // Clock
	input wire logic rst, // Sync reset
	input wire logic power_on, // Power-up clear, active high
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB ready in
	output logic hreadyout, // AHB ready out
	output logic [31:0] hrdata, // AHB read data
	output logic hresp, // AHB response
	input wire logic [7:0] input_cell, // Input cell states
	input wire logic [15:0] sector_lock, // Primary sector protection
	input wire logic [3:0] boot_lock, // Secondary sector protection
	input wire logic secure_flag, // Security flag set
	input wire logic split_space_mode, // Separate program/data space mode
	input wire logic program_fetch_strobe, // Program fetch strobe
	input wire logic read_strobe, // Read strobe
	input wire logic [7:0] addr_low, // Low address bits
	input wire logic logic_clock_input, // Logic clock input
	input wire logic [2:0] control_pin, // Control pins 2:0
	input wire logic latch_strobe, // Address latch strobe
	input wire logic high_byte_write_strobe, // High-byte write strobe
	output logic [7:0] cell_out_a, // Output cells group A
	output logic [7:0] cell_out_b, // Output cells group B
	output logic scan_port_on, // Scan port enable
	output logic [7:0] page_value, // Page inputs to array
	output logic auto_power_down, // Automatic power-down enable
	output logic array_turbo, // Turbo active
	output logic array_clock, // Clock into AND array
	output logic cell_clock, // Clock into macrocells
	output logic [7:0] array_addr, // Address into array
	output logic [2:0] array_control, // Control pins into array
	output logic array_latch, // Latch strobe into array
	output logic array_high_write, // High-byte strobe into array
	output logic sram_fetch_allow, // Fetch strobe to SRAM
	output logic secondary_fetch_allow, // Fetch strobe to secondary flash
	output logic primary_fetch_allow, // Fetch strobe to primary flash
	output logic secondary_read_allow, // Read strobe to secondary flash
	output logic primary_read_allow, // Read strobe to primary flash
	output logic periph_mode_f // Port F peripheral mode
);
	csr_wr_if rif();
	csr_byte_t mask_a_ff;
	csr_byte_t mask_b_ff;
	csr_byte_t power_0_ff;
	csr_byte_t power_2_ff;
	csr_byte_t map_ff;
	csr_byte_t boot_rd;
	csr_byte_t rd_mux;
	csr_byte_t map_eff;
	logic wr_cell_a;
	logic wr_cell_b;

	////////////////////////////////////////////////////////////////////////
	// Bus front end

	csr_ahb_slave u_slave
	(
		.mclk(mclk),
		.rst(rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.rif(rif)
	);

	always_ff @(posedge mclk)
	begin
		hresp <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer, looked up with the address-phase index

	assign boot_rd = {secure_flag, 3'b000, boot_lock};

	always_comb
	begin
		unique case (haddr[9:2])
			`CSR_IDX_INPUT_CELL: rd_mux = input_cell;
			`CSR_IDX_OUT_A: rd_mux = cell_out_a;
			`CSR_IDX_OUT_B: rd_mux = cell_out_b;
			`CSR_IDX_MASK_A: rd_mux = mask_a_ff;
			`CSR_IDX_MASK_B: rd_mux = mask_b_ff;
			`CSR_IDX_POWER_0: rd_mux = power_0_ff;
			`CSR_IDX_POWER_2: rd_mux = power_2_ff;
			`CSR_IDX_LOCK_LOW: rd_mux = sector_lock[7:0];
			`CSR_IDX_LOCK_HIGH: rd_mux = sector_lock[15:8];
			`CSR_IDX_BOOT_LOCK: rd_mux = boot_rd;
			`CSR_IDX_SCAN_PORT: rd_mux = {7'h00, scan_port_on};
			`CSR_IDX_PAGE: rd_mux = page_value;
			`CSR_IDX_SPACE_MAP: rd_mux = map_ff;
			`CSR_IDX_SIZE_0: rd_mux = {SRAM_SIZE_CODE, PRIMARY_SIZE_CODE};
			`CSR_IDX_SIZE_1: rd_mux = SIZE_1_VALUE;
			default: rd_mux = 8'h00;
		endcase
	end
	assign rif.rdata = rd_mux;

	// Only writable indices decode; read-only ones fall through
	assign wr_cell_a = rif.wr_en && (rif.index == `CSR_IDX_OUT_A);
	assign wr_cell_b = rif.wr_en && (rif.index == `CSR_IDX_OUT_B);

	////////////////////////////////////////////////////////////////////////
	// Output cells and masks, per bit

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_cell
			always_ff @(posedge mclk)
			begin
				if (rst)
					cell_out_a[gi] <= 1'b0;
				else if (wr_cell_a && !mask_a_ff[gi])
					cell_out_a[gi] <= rif.wdata[gi];
			end
			always_ff @(posedge mclk)
			begin
				if (rst)
					cell_out_b[gi] <= 1'b0;
				else if (wr_cell_b && !mask_b_ff[gi])
					cell_out_b[gi] <= rif.wdata[gi];
			end
		end
	endgenerate

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mask_a_ff <= `CSR_RESET_BYTE;
			mask_b_ff <= `CSR_RESET_BYTE;
		end
		else if (rif.wr_en)
		begin
			if (rif.index == `CSR_IDX_MASK_A)
				mask_a_ff <= rif.wdata;
			if (rif.index == `CSR_IDX_MASK_B)
				mask_b_ff <= rif.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Scan port and page

	always_ff @(posedge mclk)
	begin
		if (rst)
			scan_port_on <= 1'b0;
		else if (rif.wr_en && rif.index == `CSR_IDX_SCAN_PORT)
			scan_port_on <= rif.wdata[0];
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			page_value <= `CSR_RESET_BYTE;
		else if (rif.wr_en && rif.index == `CSR_IDX_PAGE)
			page_value <= rif.wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Power control, cleared by power-up only

	always_ff @(posedge mclk)
	begin
		if (power_on)
			power_0_ff <= `CSR_RESET_BYTE;
		else if (rif.wr_en && rif.index == `CSR_IDX_POWER_0)
			power_0_ff <= rif.wdata & `CSR_POWER_0_WMASK;
	end

	always_ff @(posedge mclk)
	begin
		if (power_on)
			power_2_ff <= `CSR_RESET_BYTE;
		else if (rif.wr_en && rif.index == `CSR_IDX_POWER_2)
			power_2_ff <= rif.wdata & `CSR_POWER_2_WMASK;
	end

	always_ff @(posedge mclk)
	begin
		if (power_on)
		begin
			auto_power_down <= 1'b0;
			array_turbo <= 1'b1;
			array_clock <= 1'b0;
			cell_clock <= 1'b0;
		end
		else
		begin
			auto_power_down <= power_0_ff[`CSR_P0_AUTO_PD];
			array_turbo <= !power_0_ff[`CSR_P0_TURBO_OFF];
			array_clock <= logic_clock_input && !power_0_ff[`CSR_P0_ARRAY_CLK_OFF];
			cell_clock <= logic_clock_input && !power_0_ff[`CSR_P0_CELL_CLK_OFF];
		end
	end

	// Gated array inputs, low when disconnected
	always_ff @(posedge mclk)
	begin
		if (power_on)
		begin
			array_addr <= 8'h00;
			array_control <= 3'b000;
			array_latch <= 1'b0;
			array_high_write <= 1'b0;
		end
		else
		begin
			array_addr <= power_2_ff[`CSR_P2_ADDR_OFF] ? 8'h00 : addr_low;
			array_control[0] <= control_pin[0] && !power_2_ff[`CSR_P2_CTL0_OFF];
			array_control[1] <= control_pin[1] && !power_2_ff[`CSR_P2_CTL1_OFF];
			array_control[2] <= control_pin[2] && !power_2_ff[`CSR_P2_CTL2_OFF];
			array_latch <= latch_strobe && !power_2_ff[`CSR_P2_LATCH_OFF];
			array_high_write <= high_byte_write_strobe && !power_2_ff[`CSR_P2_WRH_OFF];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory space map

	always_ff @(posedge mclk)
	begin
		if (rst)
			map_ff <= {3'b000, MAP_CONFIG, 1'b0};
		else if (rif.wr_en && rif.index == `CSR_IDX_SPACE_MAP)
			map_ff <= rif.wdata & `CSR_SPACE_MAP_WMASK;
	end

	// Outside split-space mode every strobe passes
	assign map_eff = split_space_mode ? map_ff : 8'hFF;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sram_fetch_allow <= 1'b0;
			secondary_fetch_allow <= 1'b0;
			primary_fetch_allow <= 1'b0;
			secondary_read_allow <= 1'b0;
			primary_read_allow <= 1'b0;
			periph_mode_f <= 1'b0;
		end
		else
		begin
			sram_fetch_allow <= program_fetch_strobe && map_eff[`CSR_MAP_SRAM_FETCH];
			secondary_fetch_allow <= program_fetch_strobe && map_eff[`CSR_MAP_SEC_FETCH];
			primary_fetch_allow <= program_fetch_strobe && map_eff[`CSR_MAP_PRI_FETCH];
			secondary_read_allow <= read_strobe && map_eff[`CSR_MAP_SEC_READ];
			primary_read_allow <= read_strobe && map_eff[`CSR_MAP_PRI_READ];
			periph_mode_f <= map_ff[`CSR_MAP_PERIPH];
		end
	end
endmodule : csr_bank

// file: dv/csr_logic_model.sv
// Model of the logic array side: status levels, strobes and gated inputs
`timescale 1ns/100ps
module csr_logic_model
(
	input wire logic mclk, // Clock
	input wire logic hold, // Freeze levels
	output logic [47:0] lv // Packed levels
);
	logic [31:0] s_ff = 32'h1357_9BDF;
	// Levels change only after a clock edge, never between
	always_ff @(posedge mclk)
	begin
		if (!hold)
			s_ff <= {s_ff[30:0], s_ff[31] ^ s_ff[21] ^ s_ff[1] ^ s_ff[0]};
	end
	assign lv = {s_ff[15:0], s_ff};
endmodule : csr_logic_model

// file: dv/csr_bank_monitor.sv
// Port-level checks for the register bank
`timescale 1ns/100ps
module csr_bank_monitor
(
	input wire logic mclk, // Clock
	input wire logic rst, // Reset
	input wire logic power_on, // Power-up clear
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer
	input wire logic hwrite, // Write
	input wire logic hready, // Ready
	input wire logic split_space_mode, // Split mode
	input wire logic program_fetch_strobe, // Fetch in
	input wire logic read_strobe, // Read in
	input wire logic [7:0] addr_low, // Address in
	input wire logic logic_clock_input, // Clock in
	input wire logic [2:0] control_pin, // Controls in
	input wire logic [7:0] cell_out_a, // Cells A
	input wire logic [7:0] page_value, // Page
	input wire logic auto_power_down, // Power-down
	input wire logic array_turbo, // Turbo
	input wire logic array_clock, // Array clock
	input wire logic [7:0] array_addr, // Array address
	input wire logic [2:0] array_control, // Array controls
	input wire logic sram_fetch_allow, // SRAM fetch
	input wire logic primary_fetch_allow, // Primary fetch
	input wire logic primary_read_allow, // Primary read
	input wire logic periph_mode_f // Port F mode
);
	logic wa_ff;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// Address phase of a write to cell group A
	always_ff @(posedge mclk)
		wa_ff <= !rst && hsel && hready && htrans[1] && hwrite && haddr == 32'h80;
	sequence a_change;
		!$past(rst) ##0 $changed(cell_out_a);
	endsequence
	chk_addr_gate: assert property ((array_addr & ~$past(addr_low)) == 8'h00)
		else $error("array address passes a blocked bit");
	chk_ctl_gate: assert property ((array_control & ~$past(control_pin)) == 3'h0)
		else $error("array control passes a blocked bit");
	chk_sram_fetch: assert property (sram_fetch_allow |-> $past(program_fetch_strobe))
		else $error("sram fetch without strobe");
	chk_pri_read: assert property (primary_read_allow |-> $past(read_strobe))
		else $error("primary read without strobe");
	chk_split_pass: assert property ($past(!split_space_mode && !rst) |->
		primary_fetch_allow == $past(program_fetch_strobe))
		else $error("fetch strobe gated outside split mode");
	chk_clk_gate: assert property (array_clock |-> $past(logic_clock_input))
		else $error("array clock without clock input");
	chk_power_hold: assert property (disable iff (power_on) (rst && !power_on)[*4] |->
		$stable(array_turbo) && $stable(auto_power_down))
		else $error("power controls changed by reset");
	chk_reset_clear: assert property ($fell(rst) |=> page_value == 8'h00 && !periph_mode_f)
		else $error("page or port F mode not cleared");
	chk_cell_write: assert property (a_change |-> $past(wa_ff))
		else $error("cells A changed without a write");
endmodule : csr_bank_monitor
bind csr_bank csr_bank_monitor mon (.*);

// file: dv/config_status_register_bank_bench.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
module config_status_register_bank_bench;
	logic mclk, rst, power_on, hsel, hwrite, hready, split_space_mode, hold;
	logic [31:0] haddr, hwdata, hrdata, seed, d;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [47:0] lv;
	logic hreadyout, hresp, scan_port_on, auto_power_down, array_turbo, array_clock, cell_clock;
	logic array_latch, array_high_write, periph_mode_f, secure_flag, read_strobe, latch_strobe;
	logic sram_fetch_allow, secondary_fetch_allow, primary_fetch_allow, program_fetch_strobe;
	logic secondary_read_allow, primary_read_allow, logic_clock_input, high_byte_write_strobe;
	logic [7:0] cell_out_a, cell_out_b, page_value, array_addr, input_cell, addr_low;
	logic [15:0] sector_lock;
	logic [3:0] boot_lock;
	logic [2:0] array_control, control_pin;
	logic [7:0] m [256];
	logic [7:0] regs [17] = '{8'h0A, 8'h20, 8'h21, 8'h22, 8'h23, 8'hB0, 8'hB4, 8'hC0, 8'hC1,
		8'hC2, 8'hC7, 8'hE0, 8'hE2, 8'hF0, 8'hF1, 8'h00, 8'hFF};
	int fails, checks_done, i;
	assign {high_byte_write_strobe, latch_strobe, control_pin, addr_low, logic_clock_input,
		read_strobe, program_fetch_strobe, secure_flag, boot_lock, sector_lock, input_cell} = lv[44:0];
	assign hready = hreadyout;
	csr_bank dut (.*);
	csr_logic_model far (.mclk(mclk), .hold(hold), .lv(lv));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wt();
		int n;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fails++;
			complete_run();
		end
	endtask : wt
	task automatic bus(logic w, logic [7:0] x, logic [7:0] dt, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {22'h0, x, 2'b00};
		wt();
		htrans <= 2'b00;
		hwdata <= {24'h0, dt};
		wt();
		q = hrdata;
	endtask : bus
	task automatic wr(logic [7:0] x, logic [7:0] dt);
		logic [31:0] q;
		bus(1'b1, x, dt, q);
		// Idle cycle so a following read sees the landed write
		@(posedge mclk);
		case (x)
			8'h20, 8'h21: m[x] = m[x] & m[x + 8'h02] | dt & ~m[x + 8'h02];
			8'hB0: m[x] = dt & 8'h3A;
			8'hB4: m[x] = dt & 8'h7D;
			8'hC7: m[x] = dt & 8'h01;
			8'hE2: m[x] = dt & 8'h9F;
			8'h22, 8'h23, 8'hE0: m[x] = dt;
			default: ;
		endcase
	endtask : wr
	task automatic rd(logic [7:0] x);
		logic [31:0] q;
		bus(1'b0, x, 8'h00, q);
		chk($sformatf("register %h", x), {24'h0, m[x]}, q);
	endtask : rd
	task automatic ro();
		m[8'h0A] = input_cell;
		m[8'hC0] = sector_lock[7:0];
		m[8'hC1] = sector_lock[15:8];
		m[8'hC2] = {secure_flag, 3'b000, boot_lock};
	endtask : ro
	task automatic outs();
		logic [7:0] p, q, v;
		p = m[8'hB0];
		q = m[8'hB4];
		v = m[8'hE2];
		chk("cells", {m[8'h21], m[8'h20]}, {cell_out_b, cell_out_a});
		chk("page", m[8'hE0], page_value);
		chk("scan", m[8'hC7][0], scan_port_on);
		chk("power", {p[1], !p[3]}, {auto_power_down, array_turbo});
		chk("clocks", {2{logic_clock_input}} & ~p[5:4], {cell_clock, array_clock});
		chk("addr", addr_low & {8{!q[0]}}, array_addr);
		chk("ctl", {high_byte_write_strobe, latch_strobe, control_pin} & ~q[6:2],
			{array_high_write, array_latch, array_control});
		chk("fetch", {3{program_fetch_strobe}} & (split_space_mode ? v[2:0] : 3'h7),
			{primary_fetch_allow, secondary_fetch_allow, sram_fetch_allow});
		chk("read", {2{read_strobe}} & (split_space_mode ? v[4:3] : 2'h3),
			{primary_read_allow, secondary_read_allow});
		chk("periph", v[7], periph_mode_f);
		chk("bus status", 32'h1, {hresp, hreadyout});
	endtask : outs
	////////////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst, power_on, hold, hsize} = 6'h3A;
		{hsel, hwrite, split_space_mode, htrans, haddr, hwdata} = '0;
		{fails, checks_done, seed} = {64'h0, 32'hA9AF9E70};
		foreach (m[j])
			m[j] = 8'h00;
		m[8'hF0] = 8'h56;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		power_on <= 1'b0;
		ro();
		foreach (regs[j])
			rd(regs[j]);
		$display("test reset values done");
		for (i = 0; i < 60; i++)
		begin
			d = rnd();
			split_space_mode <= d[8];
			wr(regs[d[31:16] % 17], d[7:0]);
			rd(regs[d[31:16] % 17]);
			repeat (2) @(posedge mclk);
			outs();
		end
		$display("test random access done");
		wr(8'hB0, 8'h2A);
		wr(8'hB4, 8'h55);
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		foreach (regs[j])
			if (regs[j] inside {8'h20, 8'h21, 8'h22, 8'h23, 8'hC7, 8'hE0, 8'hE2})
				m[regs[j]] = 8'h00;
		hold <= 1'b0;
		repeat (9) @(posedge mclk);
		hold <= 1'b1;
		repeat (3) @(posedge mclk);
		ro();
		outs();
		foreach (regs[j])
			rd(regs[j]);
		$display("test mid-run reset done");
		hold <= 1'b0;
		for (i = 0; i < 300; i++)
		begin
			d = rnd();
			split_space_mode <= d[3];
			@(posedge mclk);
		end
		$display("test free-running levels done");
		complete_run();
	end
endmodule : config_status_register_bank_bench
